// *** afg_apply_hold.v ***
`timescale 1ns/1ps
`default_nettype none

// ==============================================
// holds the last valid code applied to the analog path
module afg_apply_hold #(
  parameter       W   = 5,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] code_i,
  input  wire         valid_i,
  output reg  [W-1:0] q_o,
  output reg          chg_o
);

  // take a new code only when valid and different
  always @(posedge clk_i) begin
    if (rst_i) begin
      q_o   <= RST;
      chg_o <= 1'b0;
    end else if (ce_i) begin
      if (valid_i && (code_i != q_o)) begin
        q_o   <= code_i;
        chg_o <= 1'b1;
      end else begin
        chg_o <= 1'b0;
      end
    end
  end

endmodule // afg_apply_hold

`default_nettype wire

// *** afg_defines.vh ***
`ifndef AFG_DEFINES_VH
`define AFG_DEFINES_VH

// ==============================================
// register word indices (byte address = index * 4)
`define AFG_IDX_ROUTE      6'h0E
`define AFG_IDX_CUTOFF     6'h0F
`define AFG_IDX_OFFSET     6'h10
`define AFG_IDX_GAIN       6'h11
`define AFG_IDX_STATUS     6'h1F

// ==============================================
// reset values
`define AFG_RST_ROUTE      8'h00
`define AFG_RST_CUTOFF     8'h90
`define AFG_RST_OFFSET     8'h20
`define AFG_RST_GAIN       8'h04

// ==============================================
// writable bits per register, unused bits read zero
`define AFG_MASK_ROUTE     8'h08
`define AFG_MASK_CUTOFF    8'hF8
`define AFG_MASK_OFFSET    8'h3F
`define AFG_MASK_GAIN      8'h07

// ==============================================
// field positions
`define AFG_ROUTE_EN_BIT   3
`define AFG_CUT_MSB        7
`define AFG_CUT_LSB        3
`define AFG_CUT_HALF_BIT   4
`define AFG_CUT_RSV_BIT    3
`define AFG_OFS_MSB        5
`define AFG_GAIN_MSB       2
`define AFG_STAT_CUT_BIT   0
`define AFG_STAT_GAIN_BIT  1

// ==============================================
// cutoff multiplier in sixteenths: 1.25 = 20/16
`define AFG_CUT_MULT_BASE  5'h14
// gain codes and gains in dB
`define AFG_GAIN_C0        3'h0
`define AFG_GAIN_C1        3'h1
`define AFG_GAIN_C2        3'h2
`define AFG_GAIN_C3        3'h3
`define AFG_GAIN_C4        3'h4
`define AFG_GAIN_C5        3'h5
`define AFG_GAIN_17DB      6'h11
`define AFG_GAIN_23DB      6'h17
`define AFG_GAIN_29DB      6'h1D
`define AFG_GAIN_35DB      6'h23
// decoded values seen after reset
`define AFG_RST_CUT_CODE   5'h12
`define AFG_RST_GAIN_CODE  3'h4
`define AFG_RST_CUT_MULT   5'h12
`define AFG_RST_CUT_THIRD  1'b1
`define AFG_RST_OFS_CODE   6'h20
// read data padding above the byte lane
`define AFG_RD_PAD         24'h000000
`define AFG_RD_ZERO        32'h00000000
// cutoff step field and its multipliers in sixteenths
`define AFG_CUT_STEP_MSB   2
`define AFG_CUT_STEP0      3'h0
`define AFG_CUT_STEP1      3'h1
`define AFG_CUT_STEP2      3'h2
`define AFG_CUT_STEP3      3'h3
`define AFG_CUT_STEP4      3'h4
`define AFG_CUT_STEP5      3'h5
`define AFG_CUT_STEP6      3'h6
`define AFG_CUT_STEP7      3'h7
`define AFG_CUT_MULT_S0    5'h14
`define AFG_CUT_MULT_S1    5'h13
`define AFG_CUT_MULT_S2    5'h12
`define AFG_CUT_MULT_S3    5'h11
`define AFG_CUT_MULT_S4    5'h10
`define AFG_CUT_MULT_S5    5'h0F
`define AFG_CUT_MULT_S6    5'h0E
`define AFG_CUT_MULT_S7    5'h0D

`endif

// *** afg_filter_gain_regs.v ***
`timescale 1ns/1ps
`default_nettype none
`include "afg_defines.vh"

module afg_filter_gain_regs (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // analog path controls
  output reg         test_route_en_o,
  output reg  [4:0]  cutoff_mult_o,
  output reg         cutoff_third_o,
  output reg         cutoff_update_o,
  output reg  [5:0]  preamp_offset_o,
  output reg  [5:0]  gain_db_o,
  output reg  [2:0]  gain_code_o,
  output reg         gain_update_o,
  output reg         cutoff_rsv_o,
  output reg         gain_rsv_o
);

  // ==============================================
  // bus decode
  wire [5:0] word_idx;
  wire       bus_req;
  wire       wr_take;
  wire       rd_take;
  wire       sel_route;
  wire       sel_cutoff;
  wire       sel_offset;
  wire       sel_gain;

  // word index, low two address bits ignored
  assign word_idx   = wb_adr_i[7:2];
  assign bus_req    = wb_cyc_i & wb_stb_i;
  // write lands on the edge the master sees ack
  assign wr_take    = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  // read data is loaded on the taking edge, the same edge that raises ack
  assign rd_take    = bus_req & ~wb_ack_o & ~wb_we_i;
  assign sel_route  = (word_idx == `AFG_IDX_ROUTE);
  assign sel_cutoff = (word_idx == `AFG_IDX_CUTOFF);
  assign sel_offset = (word_idx == `AFG_IDX_OFFSET);
  assign sel_gain   = (word_idx == `AFG_IDX_GAIN);

  // ==============================================
  // per-register write strobes
  wire       wr_route;
  wire       wr_cutoff;
  wire       wr_offset;
  wire       wr_gain;

  // one strobe per word, so at most one cell loads per edge
  assign wr_route   = wr_take & sel_route;
  assign wr_cutoff  = wr_take & sel_cutoff;
  assign wr_offset  = wr_take & sel_offset;
  assign wr_gain    = wr_take & sel_gain;

  // ==============================================
  // register storage
  // each cell masks its unused bits so they read back zero
  wire [7:0] route_q;
  wire [7:0] cutoff_q;
  wire [7:0] offset_q;
  wire [7:0] gain_q;

  afg_reg_cell #(
    .RST  (`AFG_RST_ROUTE),
    .MASK (`AFG_MASK_ROUTE)
  ) u_route (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .we_i  (wr_route),
    .d_i   (wb_dat_i[7:0]),
    .q_o   (route_q)
  );

  afg_reg_cell #(
    .RST  (`AFG_RST_CUTOFF),
    .MASK (`AFG_MASK_CUTOFF)
  ) u_cutoff (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .we_i  (wr_cutoff),
    .d_i   (wb_dat_i[7:0]),
    .q_o   (cutoff_q)
  );

  afg_reg_cell #(
    .RST  (`AFG_RST_OFFSET),
    .MASK (`AFG_MASK_OFFSET)
  ) u_offset (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .we_i  (wr_offset),
    .d_i   (wb_dat_i[7:0]),
    .q_o   (offset_q)
  );

  afg_reg_cell #(
    .RST  (`AFG_RST_GAIN),
    .MASK (`AFG_MASK_GAIN)
  ) u_gain (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .we_i  (wr_gain),
    .d_i   (wb_dat_i[7:0]),
    .q_o   (gain_q)
  );

  // ==============================================
  // reserved code detection
  // flags look at the stored code, not the applied one
  wire [4:0] cut_code;
  wire [2:0] gain_code;
  wire       cut_rsv;
  wire       gain_rsv;

  assign cut_code  = cutoff_q[`AFG_CUT_MSB:`AFG_CUT_LSB];
  assign gain_code = gain_q[`AFG_GAIN_MSB:0];
  // x1xxx codes reserved in both halves
  assign cut_rsv   = cut_code[`AFG_CUT_RSV_BIT];
  assign gain_rsv  = (gain_code > `AFG_GAIN_C5);

  // ==============================================
  // applied settings, last valid code kept
  wire [4:0] cut_apply;
  wire       cut_chg;
  wire [2:0] gain_apply;
  wire       gain_chg;

  // reserved cutoff codes never reach the filter
  // stored codes stay readable; only valid ones move the filter
  afg_apply_hold #(
    .W   (5),
    .RST (`AFG_RST_CUT_CODE)
  ) u_cut_hold (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .code_i  (cut_code),
    .valid_i (~cut_rsv),
    .q_o     (cut_apply),
    .chg_o   (cut_chg)
  );

  // reserved gain codes never reach the amplifier
  // stored codes stay readable; only valid ones move the gain
  afg_apply_hold #(
    .W   (3),
    .RST (`AFG_RST_GAIN_CODE)
  ) u_gain_hold (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .code_i  (gain_code),
    .valid_i (~gain_rsv),
    .q_o     (gain_apply),
    .chg_o   (gain_chg)
  );

  // ==============================================
  // cutoff decode
  reg [4:0] cut_mult_d;
  reg       cut_third_d;

  // both halves share one step table, only the fs divisor differs
  // multiplier in sixteenths, 1.25 down one step per code
  always @* begin
    cut_third_d = cut_apply[`AFG_CUT_HALF_BIT];
    case (cut_apply[`AFG_CUT_STEP_MSB:0])
      `AFG_CUT_STEP0: cut_mult_d = `AFG_CUT_MULT_S0;
      `AFG_CUT_STEP1: cut_mult_d = `AFG_CUT_MULT_S1;
      `AFG_CUT_STEP2: cut_mult_d = `AFG_CUT_MULT_S2;
      `AFG_CUT_STEP3: cut_mult_d = `AFG_CUT_MULT_S3;
      `AFG_CUT_STEP4: cut_mult_d = `AFG_CUT_MULT_S4;
      `AFG_CUT_STEP5: cut_mult_d = `AFG_CUT_MULT_S5;
      `AFG_CUT_STEP6: cut_mult_d = `AFG_CUT_MULT_S6;
      `AFG_CUT_STEP7: cut_mult_d = `AFG_CUT_MULT_S7;
      default:        cut_mult_d = `AFG_CUT_MULT_S0; // all steps listed
    endcase
  end

  // ==============================================
  // gain decode
  reg [5:0] gain_db_d;

  always @* begin
    case (gain_apply)
      // low codes 17 dB, then 23 dB
      `AFG_GAIN_C0: gain_db_d = `AFG_GAIN_17DB;
      `AFG_GAIN_C1: gain_db_d = `AFG_GAIN_17DB;
      `AFG_GAIN_C2: gain_db_d = `AFG_GAIN_17DB;
      `AFG_GAIN_C3: gain_db_d = `AFG_GAIN_23DB;
      `AFG_GAIN_C4: gain_db_d = `AFG_GAIN_29DB;
      `AFG_GAIN_C5: gain_db_d = `AFG_GAIN_35DB;
      default:      gain_db_d = `AFG_GAIN_29DB; // unreachable via hold
    endcase
  end

  // ==============================================
  // analog control outputs, all registered
  // every output comes from a flop so the analog switches see no glitch
  // reset values match the decode of the register reset values

  // route enable drives the test pin switch
  always @(posedge clk_i) begin
    if (rst_i) begin
      test_route_en_o <= 1'b0;
    end else if (ce_i) begin
      test_route_en_o <= route_q[`AFG_ROUTE_EN_BIT];
    end
  end

  // offset code straight to the trim dac
  // binary code, monotonic low to high
  always @(posedge clk_i) begin
    if (rst_i) begin
      preamp_offset_o <= `AFG_RST_OFS_CODE;
    end else if (ce_i) begin
      preamp_offset_o <= offset_q[`AFG_OFS_MSB:0];
    end
  end

  // applied cutoff multiplier, band and change pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      cutoff_mult_o   <= `AFG_RST_CUT_MULT;
      cutoff_third_o  <= `AFG_RST_CUT_THIRD;
      cutoff_update_o <= 1'b0;
    end else if (ce_i) begin
      cutoff_mult_o   <= cut_mult_d;
      cutoff_third_o  <= cut_third_d;
      cutoff_update_o <= cut_chg;
    end
  end

  // applied gain, its code and change pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      gain_db_o     <= `AFG_GAIN_29DB;
      gain_code_o   <= `AFG_RST_GAIN_CODE;
      gain_update_o <= 1'b0;
    end else if (ce_i) begin
      gain_db_o     <= gain_db_d;
      gain_code_o   <= gain_apply;
      gain_update_o <= gain_chg;
    end
  end

  // reserved flags follow the stored codes
  always @(posedge clk_i) begin
    if (rst_i) begin
      cutoff_rsv_o <= 1'b0;
      gain_rsv_o   <= 1'b0;
    end else if (ce_i) begin
      cutoff_rsv_o <= cut_rsv;
      gain_rsv_o   <= gain_rsv;
    end
  end

  // ==============================================
  // read data mux
  reg [7:0] rd_byte;

  // unused bits and unmapped words read zero
  always @* begin
    rd_byte = 8'h00;
    case (word_idx)
      `AFG_IDX_ROUTE: begin
        rd_byte = route_q;
      end
      `AFG_IDX_CUTOFF: begin
        rd_byte = cutoff_q;
      end
      `AFG_IDX_OFFSET: begin
        rd_byte = offset_q;
      end
      `AFG_IDX_GAIN: begin
        rd_byte = gain_q;
      end
      `AFG_IDX_STATUS: begin
        rd_byte[`AFG_STAT_CUT_BIT]  = cutoff_rsv_o;
        rd_byte[`AFG_STAT_GAIN_BIT] = gain_rsv_o;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // ==============================================
  // wishbone handshake, one wait state
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      // ack is registered and drops next cycle: one pulse per request
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // read data loaded with the ack, held until the next read
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `AFG_RD_ZERO;
    end else if (ce_i && rd_take) begin
      wb_dat_o <= {`AFG_RD_PAD, rd_byte};
    end
  end

endmodule // afg_filter_gain_regs

`default_nettype wire

// *** afg_filter_gain_regs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==============================================
// port checks for the filter and gain slice
module afg_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        test_route_en_o,
  input wire logic [4:0]  cutoff_mult_o,
  input wire logic        cutoff_third_o,
  input wire logic        cutoff_update_o,
  input wire logic [5:0]  preamp_offset_o,
  input wire logic [5:0]  gain_db_o,
  input wire logic [2:0]  gain_code_o,
  input wire logic        gain_update_o
);
  // write that lands at this edge
  wire       req = wb_cyc_i & wb_stb_i;
  wire       wr  = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [5:0] ix  = wb_adr_i[7:2];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_after_req_a: assert property (req && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing after request");
  ack_one_cycle_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held too long");
  ack_needs_req_a: assert property (wb_ack_o |-> req && wb_dat_o[31:8] == 24'h0)
    else $error("ack without request or wide data");
  ce_freeze_a: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(gain_code_o))
    else $error("state moved with enable low");
  reset_vals_a: assert property ($fell(rst_i) |-> !test_route_en_o && cutoff_mult_o == 5'h12
    && cutoff_third_o && preamp_offset_o == 6'h20 && gain_db_o == 6'h1D)
    else $error("output reset value wrong");
  gain_table_a: assert property (gain_db_o == (gain_code_o < 3'h3 ? 6'h11 : gain_code_o == 3'h3 ? 6'h17 :
    gain_code_o == 3'h4 ? 6'h1D : 6'h23)) else $error("gain dB mismatch");
  cut_pulse_a: assert property ($past(ce_i) && !$past(rst_i) |->
    cutoff_update_o == $changed({cutoff_mult_o, cutoff_third_o})) else $error("cutoff pulse wrong");
  gain_pulse_a: assert property ($past(ce_i) && !$past(rst_i) |-> gain_update_o == $changed(gain_code_o))
    else $error("gain pulse wrong");
  route_wr_a: assert property (wr && ce_i && ix == 6'h0E ##1 ce_i |->
    ##1 test_route_en_o == $past(wb_dat_i[3], 2)) else $error("route enable not applied");
  offset_wr_a: assert property (wr && ce_i && ix == 6'h10 ##1 ce_i |->
    ##1 preamp_offset_o == $past(wb_dat_i[5:0], 2)) else $error("offset not applied");
endmodule // afg_chk

bind afg_filter_gain_regs afg_chk u_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .test_route_en_o, .cutoff_mult_o, .cutoff_third_o,
  .cutoff_update_o, .preamp_offset_o, .gain_db_o, .gain_code_o, .gain_update_o);
`default_nettype wire

// *** afg_reg_cell.v ***
`timescale 1ns/1ps
`default_nettype none

// ==============================================
// one software register with reset value and write mask
module afg_reg_cell #(
  parameter [7:0] RST  = 8'h00,
  parameter [7:0] MASK = 8'hFF
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       we_i,
  input  wire [7:0] d_i,
  output reg  [7:0] q_o
);

  // masked store, unused bits stay zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= RST;
    end else if (ce_i && we_i) begin
      q_o <= d_i & MASK;
    end
  end

endmodule // afg_reg_cell

`default_nettype wire

// *** tb_afg_filter_gain_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==============================================
// bench for the filter and gain slice
module tb_afg_filter_gain_regs;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        ce_i     = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] rd_q;
  int          fail_count = 0;
  int          total_checks = 0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, test_route_en_o, cutoff_third_o;
  wire  [4:0]  cutoff_mult_o;
  wire  [5:0]  preamp_offset_o, gain_db_o;

  afg_filter_gain_regs DUT (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .test_route_en_o, .cutoff_mult_o, .cutoff_third_o,
    .cutoff_update_o(), .preamp_offset_o, .gain_db_o, .gain_code_o(), .gain_update_o(),
    .cutoff_rsv_o(), .gain_rsv_o());

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic bus cycle, bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      chk("ack wait", 32'h1, {31'h0, wb_ack_o});
      wrap_up();
    end
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00, 4'hF);
    chk(nm, e, rd_q);
  endtask

  // reset values of registers and the cutoff multiplier output
  task automatic t_reset;
    rdc("route", 8'h38, 32'h00);
    rdc("cutoff", 8'h3C, 32'h90);
    rdc("offset", 8'h40, 32'h20);
    rdc("gain", 8'h44, 32'h04);
    rdc("status", 8'h7C, 32'h00);
    chk("mult", 32'h12, {27'h0, cutoff_mult_o});
  endtask

  // route enable and its write mask
  task automatic t_route;
    wr(8'h38, 8'hFF);
    rdc("route mask", 8'h38, 32'h08);
    chk("route on", 32'h1, {31'h0, test_route_en_o});
    wr(8'h38, 8'hF7);
    rdc("route off", 8'h38, 32'h00);
    chk("route off", 32'h0, {31'h0, test_route_en_o});
  endtask

  // every valid cutoff code, then a reserved one
  task automatic t_cutoff;
    logic [4:0] c;
    for (int i = 0; i < 16; i++) begin
      c = {i[3], 1'b0, i[2:0]};
      // codes only, sample rate not modelled
      wr(8'h3C, {c, 3'h0});
      repeat (2) @(posedge clk_i);
      chk("mult", 32'h14 - i[2:0], {27'h0, cutoff_mult_o});
      chk("third", {31'h0, i[3]}, {31'h0, cutoff_third_o});
    end
    wr(8'h3C, 8'h47);
    repeat (2) @(posedge clk_i);
    rdc("cut rsv", 8'h3C, 32'h40);
    chk("mult held", 32'h0D, {27'h0, cutoff_mult_o});
    rdc("status", 8'h7C, 32'h01);
  endtask

  // offset extremes and masked upper bits
  task automatic t_offset;
    logic [7:0] v[3];
    v = '{8'h00, 8'hFF, 8'h15};
    foreach (v[k]) begin
      wr(8'h40, v[k]);
      rdc("offset", 8'h40, {26'h0, v[k][5:0]});
      chk("offset out", {26'h0, v[k][5:0]}, {26'h0, preamp_offset_o});
    end
  endtask

  // gain table, reserved code, byte select, unmapped
  task automatic t_gain;
    logic [5:0] g[6];
    g = '{6'h11, 6'h11, 6'h11, 6'h17, 6'h1D, 6'h23};
    for (int i = 0; i < 6; i++) begin
      wr(8'h44, {5'h1F, i[2:0]});
      repeat (2) @(posedge clk_i);
      chk("gain_db", {26'h0, g[i]}, {26'h0, gain_db_o});
      rdc("gain", 8'h44, i);
    end
    wr(8'h44, 8'h06);
    repeat (2) @(posedge clk_i);
    chk("gain held", 32'h23, {26'h0, gain_db_o});
    rdc("status", 8'h7C, 32'h03);
    wb(1'b1, 8'h44, 8'h01, 4'hE);
    rdc("no sel", 8'h44, 32'h06);
    wr(8'h00, 8'hFF);
    rdc("unmapped", 8'h00, 32'h00);
  endtask

  // enable low stalls a pending write, which lands once enable returns
  task automatic t_freeze;
    ce_i <= 1'b0;
    fork
      wr(8'h40, 8'h2A);
      begin
        repeat (3) @(posedge clk_i);
        chk("frozen ack", 32'h0, {31'h0, wb_ack_o});
        chk("frozen offset", 32'h15, {26'h0, preamp_offset_o});
        ce_i <= 1'b1;
      end
    join
    rdc("thawed", 8'h40, 32'h2A);
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_route();
    t_cutoff();
    t_offset();
    t_freeze();
    t_gain();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    wrap_up();
  end
endmodule // tb_afg_filter_gain_regs
`default_nettype wire
